// ===== tws_fifo.sv
// Purpose: small valid/ready fifo for received bytes
// Assumes: single clock, power of two depth
// Notes:   full and empty are exact
`timescale 1ns/100ps
module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  wire              full  = (wp_r[AW] != rp_r[AW]) &&
                            (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire              empty = (wp_r == rp_r);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rp_r[AW-1:0]];
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// ===== tws_peer.sv
// Purpose: far-side serial device
// Assumes: clock line idles high between frames
// Notes:   data line changes only on falling clock line edges, so it holds once its frame is done
`timescale 1ns/100ps
module tws_peer (
  input  wire logic       i_go,
  input  wire logic [7:0] i_tx,
  input  wire logic       i_pin,
  input  wire logic       i_so,
  output logic            o_sck,
  output logic            o_si,
  output logic [7:0]      o_rx
);
  logic [7:0] tx_r;
  initial begin
    {o_sck, o_si, o_rx, tx_r} = 18'h20000;
  end
  // eight 125 ns clocks per frame
  always @(posedge i_go) begin
    tx_r = i_tx;
    repeat (8) begin
      #62.5 o_sck = 1'b0;
      #62.5 o_sck = 1'b1;
    end
  end
  always @(negedge i_pin) begin
    o_si = tx_r[7];
    tx_r = {tx_r[6:0], ~tx_r[7]};
  end
  always @(posedge i_pin) o_rx = {o_rx[6:0], i_so};
endmodule

// ===== tws_pkg.sv
// Purpose: constants for the three-wire serial shift unit
// Assumes: 125 MHz system clock, shift clock pin sampled in that domain
// Notes:   clock select codes follow the mode table (11 = internal clock)
// Summary of operation
// - master shift clock rate is fixed at FSC_HZ_2: master needs select code 11, which the divider maps to HALF_2
// - master drives clock pulses only until the counter reaches eight
// - in wait with master mode the clock pin is held high
// - init: master selected, clock pin high; wait cancel starts clocking
// - wait cancel during a transfer changes only the latched clock select, counter kept
// - rate and run flag written together act like cancel from initialization
// - counter counts pin edges, internal and external clocks alike
// - counter idle and unchanged while in wait
// - counter starts at zero, increments on each falling pin edge
// - rising edge at count eight clears counter and enters wait once the receive fifo has room
// - counter value is not visible to software
// - counter cleared on power-on, clock stop, run flag zero, ce reset
// - eight-bit shift register loaded by put, read by get
// - falling edge presents msb on serial out, msb first
// - rising edge captures serial in into the lsb
// - no shifting while in wait
// - no serial output when out pin is input or enable is zero
// - load in wait: msb appears on first falling edge after cancel
// - read during transfer works with pin low, corrupts with pin high
// - load during transfer with pin high drives new msb at once
// - load during transfer with pin low fails and corrupts register
// - run flag one starts transfer; hardware clears it at the end
// - run flag zero during transfer forces wait immediately
package tws_pkg;
  localparam int          CNT_W      = 4;
  localparam logic [3:0]  CNT_RST    = 4'h0;
  localparam logic [3:0]  CNT_LAST   = 4'h8;
  localparam logic [7:0]  SR_RST     = 8'h00;
  localparam logic [7:0]  SR_CORRUPT = 8'hff;
  localparam logic [1:0]  SEL_MASTER = 2'h3;
  localparam int          CLK_HZ     = 125000000;
  // shift clock rates in hz for select codes 0, 1 and 2; only code 3 masters, at the code 2 rate
  localparam int          FSC_HZ_0   = 31250;
  localparam int          FSC_HZ_1   = 62500;
  localparam int          FSC_HZ_2   = 250000;
  localparam int          HALF_0     = CLK_HZ / (2 * FSC_HZ_0);
  localparam int          HALF_1     = CLK_HZ / (2 * FSC_HZ_1);
  localparam int          HALF_2     = CLK_HZ / (2 * FSC_HZ_2);
  localparam int          DIV_W      = 12;
  localparam int          FIFO_DEPTH = 16;
  typedef enum logic {TWS_WAIT, TWS_RUN} tws_state_t;
endpackage

// ===== tws_shift_unit.sv
// Purpose: shift clock generator, clock counter and presettable shift register
// Assumes: pin inputs asynchronous, two-stage synchronised before use
// Notes:   received bytes are pushed into a fifo after each transfer
`timescale 1ns/100ps
module tws_shift_unit #(
  parameter int FIFO_DEPTH = tws_pkg::FIFO_DEPTH
) (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_clk_select_hi,
  input  wire logic       i_clk_select_lo,
  input  wire logic       i_mode_write,
  input  wire logic       i_run_wdata,
  input  wire logic       i_clock_stop,
  input  wire logic       i_ce_reset,
  input  wire logic       i_serial_out_enable,
  input  wire logic       i_so_pin_is_output,
  input  wire logic       i_put,
  input  wire logic [7:0] i_cpu_data_buffer,
  input  wire logic       i_get,
  input  wire logic       i_shift_clock_pin_in,
  input  wire logic       i_serial_in_pin,
  input  wire logic       i_rx_ready,
  output logic            o_transfer_run_flag,
  output logic [7:0]      o_get_data,
  output logic            o_shift_clock_pin_out,
  output logic            o_shift_clock_pin_oe,
  output logic            o_serial_out_pin,
  output logic            o_serial_out_oe,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data
);
  ////////////////////////////////////////////////////////////////////////
  // synchronisers and pin edges
  logic [1:0]  sck_sync_r;
  logic        sck_prev_r;
  logic [1:0]  si_sync_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_sync_r <= 2'h3;
      sck_prev_r <= 1'b1;
      si_sync_r  <= 2'h0;
    end else begin
      sck_sync_r <= {sck_sync_r[0], i_shift_clock_pin_in};
      sck_prev_r <= sck_sync_r[1];
      si_sync_r  <= {si_sync_r[0], i_serial_in_pin};
    end
  end
  wire sck_lvl  = sck_sync_r[1];
  wire sck_fall = sck_prev_r && !sck_lvl;
  wire sck_rise = !sck_prev_r && sck_lvl;
  wire si_lvl   = si_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // control decode
  tws_pkg::tws_state_t state_r;
  tws_pkg::tws_state_t state_nxt;
  logic [tws_pkg::CNT_W-1:0] cnt_r;
  logic [tws_pkg::CNT_W-1:0] cnt_nxt;
  logic [7:0]  sr_r;
  logic [7:0]  sr_nxt;
  logic        so_r;
  logic        so_nxt;
  logic [1:0]  sel_r;
  logic [tws_pkg::DIV_W-1:0] div_r;
  logic        gen_r;
  logic        fifo_ready;

  wire [1:0] sel_w     = {i_clk_select_hi, i_clk_select_lo};
  wire       master    = (sel_r == tws_pkg::SEL_MASTER);
  wire       running   = (state_r == tws_pkg::TWS_RUN);
  wire       start     = i_mode_write && i_run_wdata && !running;
  wire       force_w   = i_mode_write && !i_run_wdata;
  wire       clr       = force_w || i_clock_stop || i_ce_reset;
  wire       at_last   = (cnt_r == tws_pkg::CNT_LAST);
  // last rising edge waits while the receive fifo is full; level, not
  // the one-cycle edge pulse, so a held-off end is not lost
  wire       finish    = running && sck_lvl && at_last && fifo_ready;
  wire       pin_high  = sck_lvl;
  wire       sr_load_ok   = i_put && (!running || pin_high);
  wire       sr_load_bad  = i_put && running && !pin_high;
  wire       sr_read_bad  = i_get && running && pin_high;

  // internal clock half period select
  wire [tws_pkg::DIV_W-1:0] half_w =
    (sel_r == 2'h0) ? tws_pkg::DIV_W'(tws_pkg::HALF_0) :
    (sel_r == 2'h1) ? tws_pkg::DIV_W'(tws_pkg::HALF_1) :
                      tws_pkg::DIV_W'(tws_pkg::HALF_2);
  wire div_tick = (div_r == half_w - 1'b1);
  // stop toggling once eight falls seen; pin returns high then stops
  wire gen_stop = at_last && gen_r;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sr_nxt    = sr_r;
    so_nxt    = so_r;
    case (state_r)
      tws_pkg::TWS_WAIT: begin
        // counter frozen in wait; register changes only by put
        if (start) begin
          state_nxt = tws_pkg::TWS_RUN;
          cnt_nxt   = tws_pkg::CNT_RST;
        end
      end
      tws_pkg::TWS_RUN: begin
        // repeated cancel while running keeps counter, and waveform if the clock select written is unchanged
        if (sck_fall && !at_last) begin
          cnt_nxt = cnt_r + 1'b1;
          so_nxt  = sr_r[7];
        end else if (sck_rise && !at_last) begin
          sr_nxt = {sr_r[6:0], si_lvl};
        end else if (finish) begin
          sr_nxt    = {sr_r[6:0], si_lvl};
          cnt_nxt   = tws_pkg::CNT_RST;
          state_nxt = tws_pkg::TWS_WAIT;
        end
      end
      default: begin
        state_nxt = tws_pkg::TWS_WAIT;
      end
    endcase
    if (sr_load_ok) begin
      sr_nxt = i_cpu_data_buffer;
      if (running) begin
        so_nxt = i_cpu_data_buffer[7];
      end
    end else if (sr_load_bad || sr_read_bad) begin
      sr_nxt = tws_pkg::SR_CORRUPT;
    end
    if (clr) begin
      cnt_nxt   = tws_pkg::CNT_RST;
      state_nxt = tws_pkg::TWS_WAIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= tws_pkg::TWS_WAIT;
      cnt_r   <= tws_pkg::CNT_RST;
      sr_r    <= tws_pkg::SR_RST;
      so_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sr_r    <= sr_nxt;
      so_r    <= so_nxt;
    end
  end

  // clock select latched on mode writes
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_r <= tws_pkg::SEL_MASTER;
    end else if (i_mode_write) begin
      sel_r <= sel_w;
    end
  end

  // internal clock generator, restarts high on each new transfer
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      div_r <= '0;
      gen_r <= 1'b1;
    end else if (!running || start || !master) begin
      div_r <= '0;
      gen_r <= 1'b1;
    end else if (div_tick) begin
      div_r <= '0;
      if (!gen_stop) begin
        gen_r <= !gen_r;
      end
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_transfer_run_flag   <= 1'b0;
      o_get_data            <= 8'h00;
      o_shift_clock_pin_out <= 1'b1;
      o_shift_clock_pin_oe  <= 1'b1;
      o_serial_out_pin      <= 1'b0;
      o_serial_out_oe       <= 1'b0;
    end else begin
      o_transfer_run_flag   <= (state_nxt == tws_pkg::TWS_RUN);
      if (i_get && !sr_read_bad) begin
        o_get_data <= sr_r;
      end
      o_shift_clock_pin_out <= gen_r || (state_nxt != tws_pkg::TWS_RUN);
      o_shift_clock_pin_oe  <= (sel_r == tws_pkg::SEL_MASTER);
      o_serial_out_pin      <= so_nxt;
      o_serial_out_oe       <= i_serial_out_enable && i_so_pin_is_output;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // received bytes to the fifo; counter itself is never exported
  logic push_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      push_r <= 1'b0;
    end else begin
      push_r <= finish;
    end
  end

  logic       fifo_valid;
  logic [7:0] fifo_data;
  tws_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_in_valid  (push_r),
    .o_in_ready  (fifo_ready),
    .i_in_data   (sr_r),
    .o_out_valid (fifo_valid),
    .i_out_ready (i_rx_ready && o_rx_valid == 1'b0),
    .o_out_data  (fifo_data)
  );

  // output stage register for the fifo head
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
    end else if (!o_rx_valid && i_rx_ready && fifo_valid) begin
      o_rx_valid <= 1'b1;
      o_rx_data  <= fifo_data;
    end else if (o_rx_valid) begin
      o_rx_valid <= 1'b0;
    end
  end
endmodule

// ===== tws_shift_unit_sva.sv
// Purpose: port checks for the shift unit
// Assumes: bound to every tws_shift_unit
// Notes:   pin timing is judged by the bench
`timescale 1ns/100ps
module tws_shift_unit_sva (
  input wire logic       i_clock, i_nrst, i_mode_write, i_run_wdata,
  input wire logic       i_clock_stop, i_ce_reset, i_serial_out_enable,
  input wire logic       i_get, o_transfer_run_flag, o_shift_clock_pin_out,
  input wire logic       o_shift_clock_pin_oe, o_serial_out_pin,
  input wire logic       o_serial_out_oe,
  input wire logic [7:0] o_get_data
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire run = o_transfer_run_flag;
  a_idle_clk_high:
    assert property (!run && !$past(run) && o_shift_clock_pin_oe
      |-> o_shift_clock_pin_out) else $error("clock low in wait");
  a_start_sets_run:
    assert property (i_mode_write && i_run_wdata |=> run)
      else $error("run flag not set");
  a_forced_wait:
    assert property (i_mode_write && !i_run_wdata |=> !run)
      else $error("forced wait missed");
  a_stop_clears:
    assert property (i_clock_stop || i_ce_reset |=> !run)
      else $error("stop left run set");
  a_oe_gated:
    assert property (!i_serial_out_enable ##1 !i_serial_out_enable
      |-> !o_serial_out_oe) else $error("serial out enabled");
  a_get_holds:
    assert property (!$past(i_get) |-> $stable(o_get_data))
      else $error("get data moved");
  a_so_quiet:
    assert property (!run && !$past(run) |-> $stable(o_serial_out_pin))
      else $error("shift in wait");
  a_run_start:
    assert property ($rose(run) |-> $past(i_mode_write) && $past(i_run_wdata))
      else $error("run rose unasked");
endmodule
bind tws_shift_unit tws_shift_unit_sva u_sva (.*);

// ===== tws_shift_unit_tb.sv
// Purpose: self-checking bench for the shift unit
// Assumes: peer clocks the port in slave mode
// Notes:   master rate set by the design's divider
`timescale 1ns/100ps
module tws_shift_unit_tb;
  logic i_clock, i_nrst, i_clk_select_hi, i_clk_select_lo, i_mode_write;
  logic i_run_wdata, i_clock_stop, i_ce_reset, i_serial_out_enable, go;
  logic i_so_pin_is_output, i_put, i_get, i_serial_in_pin, i_rx_ready;
  logic [7:0] i_cpu_data_buffer, o_get_data, o_rx_data, peer_rx, ptx, last;
  logic o_transfer_run_flag, o_shift_clock_pin_out, o_shift_clock_pin_oe;
  logic o_serial_out_pin, o_serial_out_oe, o_rx_valid, peer_sck;
  wire  i_shift_clock_pin_in;
  int   miscompares, total_checks, cycles, falls;
  assign i_shift_clock_pin_in =
    o_shift_clock_pin_oe ? o_shift_clock_pin_out : peer_sck;
  tws_shift_unit dut (.*);
  tws_peer peer (.i_go(go), .i_tx(ptx), .i_pin(i_shift_clock_pin_in),
    .i_so(o_serial_out_pin), .o_sck(peer_sck), .o_si(i_serial_in_pin),
    .o_rx(peer_rx));
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task mode(input logic [1:0] s, input logic r);
    @(posedge i_clock);
    {i_clk_select_hi, i_clk_select_lo} <= s;
    {i_run_wdata, i_mode_write} <= {r, 1'b1};
    @(posedge i_clock);
    i_mode_write <= 1'b0;
  endtask
  task put(input logic [7:0] d);
    @(posedge i_clock);
    {i_put, i_cpu_data_buffer} <= {1'b1, d};
    @(posedge i_clock);
    i_put <= 1'b0;
  endtask
  task get_chk(input logic [7:0] e);
    @(posedge i_clock);
    i_get <= 1'b1;
    @(posedge i_clock);
    i_get <= 1'b0;
    @(negedge i_clock);
    chk(o_get_data, e);
    last = e;
  endtask
  // counts pin falls until the run flag drops
  task wait_idle(input logic again);
    int n;
    logic p;
    {n, p, falls} = {32'h0, 1'b1, 32'h0};
    @(negedge i_clock);
    while (o_transfer_run_flag !== 1'b0 && n < 40000) begin
      if (p === 1'b1 && i_shift_clock_pin_in === 1'b0) begin
        falls++;
        if (again && falls == 2) mode(2'h3, 1'b1);
      end
      p = i_shift_clock_pin_in;
      @(negedge i_clock);
      n++;
    end
  endtask
  task t_slave(input logic [7:0] d, input logic [7:0] p);
    put(d);
    mode(2'h0, 1'b1);
    @(posedge i_clock);
    {ptx, go} <= {p, 1'b1};
    @(posedge i_clock);
    go <= 1'b0;
    wait_idle(1'b0);
    chk(peer_rx, d);
    get_chk(p);
  endtask
  task t_drain;
    int k;
    k = 0;
    @(posedge i_clock);
    i_rx_ready <= 1'b1;
    repeat (40) begin
      @(negedge i_clock);
      if (o_rx_valid === 1'b1) begin
        chk(o_rx_data, 8'(8'h5a ^ k));
        k++;
      end
    end
    chk(8'(k), 8'h10);
  endtask
  task t_abort;
    for (int k = 0; k < 3; k++) begin
      mode(2'h0, 1'b1);
      @(negedge i_clock);
      chk(o_transfer_run_flag, 1'b1);
      if (k == 2) mode(2'h0, 1'b0);
      else begin
        @(posedge i_clock);
        {i_ce_reset, i_clock_stop} <= 2'(k + 1);
        @(posedge i_clock);
        {i_ce_reset, i_clock_stop} <= 2'h0;
      end
      @(negedge i_clock);
      chk(o_transfer_run_flag, 1'b0);
    end
    go <= 1'b1;
    repeat (150) @(posedge i_clock);
    go <= 1'b0;
    chk(o_transfer_run_flag, 1'b0);
    t_slave(8'h3c, 8'ha5);
  endtask
  task t_busy;
    mode(2'h0, 1'b1);
    put(8'h80);
    repeat (4) @(posedge i_clock);
    chk(o_serial_out_pin, 1'b1);
    put(8'h7f);
    repeat (4) @(posedge i_clock);
    chk(o_serial_out_pin, 1'b0);
    get_chk(last);
    mode(2'h0, 1'b0);
    get_chk(8'hff);
  endtask
  // access while the master clock pin is low: read good, load corrupts
  task t_low;
    put(8'h96);
    mode(2'h3, 1'b1);
    while (o_shift_clock_pin_out !== 1'b0) @(negedge i_clock);
    repeat (4) @(posedge i_clock);
    get_chk(8'h96);
    put(8'h11);
    mode(2'h3, 1'b0);
    get_chk(8'hff);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {i_nrst, i_clk_select_hi, i_clk_select_lo, i_mode_write} = 4'h0;
    {i_run_wdata, i_clock_stop, i_ce_reset, i_put, i_get} = 5'h00;
    {i_rx_ready, go, i_serial_out_enable, i_so_pin_is_output} = 4'h3;
    {i_cpu_data_buffer, ptx, last} = 24'h0;
    {miscompares, total_checks, cycles} = 96'h0;
    repeat (12) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk(o_transfer_run_flag, 1'b0);
    chk(o_shift_clock_pin_out, 1'b1);
    chk(o_shift_clock_pin_oe, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      {i_serial_out_enable, i_so_pin_is_output} <= 2'(k);
      repeat (3) @(posedge i_clock);
      chk(o_serial_out_oe, 1'(k == 3));
    end
    $display("test init done");
    for (int k = 0; k < 16; k++) t_slave(8'(8'h81 + k), 8'(8'h5a ^ k));
    t_drain();
    $display("test fifo done");
    put(8'hc3);
    mode(2'h3, 1'b1);
    wait_idle(1'b1);
    chk(8'(falls), 8'h08);
    chk(peer_rx, 8'hc3);
    chk(o_shift_clock_pin_out, 1'b1);
    $display("test master done");
    t_abort();
    $display("test abort done");
    t_busy();
    $display("test busy done");
    t_low();
    $display("test low done");
    report_and_stop();
  end
endmodule
